// *** design/bdm_pkg.sv ***
// constants, enumerations and state layout of the banked data memory and status block
// assumes one core clock; the instruction unit issues at most one command per cycle
package bdm_pkg;

    // data memory map
    localparam logic [7:0] BDM_ADDR_IND0    = 8'h00;
    localparam logic [7:0] BDM_ADDR_PTR0    = 8'h01;
    localparam logic [7:0] BDM_ADDR_IND1    = 8'h02;
    localparam logic [7:0] BDM_ADDR_PTR1    = 8'h03;
    localparam logic [7:0] BDM_ADDR_BSEL    = 8'h04;
    localparam logic [7:0] BDM_ADDR_ACC     = 8'h05;
    localparam logic [7:0] BDM_ADDR_STAT    = 8'h0a;
    localparam logic [7:0] BDM_ADDR_GP_BASE = 8'h20;
    localparam int         BDM_GP_DEPTH     = 224;

    // status field positions
    localparam int BDM_C_BIT   = 0;
    localparam int BDM_AC_BIT  = 1;
    localparam int BDM_Z_BIT   = 2;
    localparam int BDM_OV_BIT  = 3;
    localparam int BDM_PDF_BIT = 4;
    localparam int BDM_TO_BIT  = 5;
    localparam logic [7:0] BDM_STAT_SW_MASK = 8'h0f;

    // values after reset
    localparam logic [7:0] BDM_BYTE_RST = 8'h00;
    localparam logic [7:0] BDM_STAT_RST = 8'h00;

    // core command
    typedef enum logic [1:0] {
        BDM_CMD_NOP   = 2'b00,
        BDM_CMD_READ  = 2'b01,
        BDM_CMD_WRITE = 2'b10,
        BDM_CMD_ALU   = 2'b11
    } bdm_cmd_t;

    // alu operations
    typedef enum logic [4:0] {
        BDM_OP_ADD = 5'h00, BDM_OP_ADC = 5'h01, BDM_OP_SUB = 5'h02, BDM_OP_SBC = 5'h03,
        BDM_OP_DAA = 5'h04, BDM_OP_AND = 5'h05, BDM_OP_OR  = 5'h06, BDM_OP_XOR = 5'h07,
        BDM_OP_CPL = 5'h08, BDM_OP_RL  = 5'h09, BDM_OP_RR  = 5'h0a, BDM_OP_RLC = 5'h0b,
        BDM_OP_RRC = 5'h0c, BDM_OP_INC = 5'h0d, BDM_OP_DEC = 5'h0e, BDM_OP_SZ  = 5'h0f,
        BDM_OP_SNZ = 5'h10, BDM_OP_SIZ = 5'h11, BDM_OP_SDZ = 5'h12
    } bdm_op_t;

    // one alu request as the core presents it
    typedef struct packed {
        bdm_op_t    op;
        logic       use_imm;
        logic       to_acc;
    } bdm_alu_req_t;

    // whole block state
    typedef struct packed {
        logic [BDM_GP_DEPTH-1:0][7:0] ram;
        logic [7:0]                   ptr0;
        logic [7:0]                   ptr1;
        logic [7:0]                   bsel;
        logic [7:0]                   acc;
        logic [7:0]                   stat;
        logic [7:0]                   rdata;
        logic                         skip;
    } bdm_state_t;

endpackage

// *** design/bdm_top.sv ***
// banked data memory, indirect pointers, accumulator, alu and status register
// assumes the instruction unit, the watchdog and halt logic share CORE_CLK_IN
`timescale 1ns/1ps
module bdm_top import bdm_pkg::*; (
    input  wire logic       CORE_CLK_IN,
    input  wire logic       RSTN_IN,
    input  wire logic [1:0] CMD_IN,
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic [4:0] ALU_OP_IN,
    input  wire logic       ALU_IMM_IN,
    input  wire logic       ALU_TO_ACC_IN,
    input  wire logic       HALT_IN,
    input  wire logic       WATCHDOG_CLEAR_INSTRUCTION_IN,
    input  wire logic       WDT_TIMEOUT_IN,
    output logic [7:0]      RDATA_OUT,
    output logic            SKIP_OUT,
    output logic [7:0]      ACC_OUT,
    output logic [7:0]      STATUS_OUT
);

    logic         rst_meta;
    logic         rst_n;
    bdm_state_t   q;
    bdm_state_t   next_q;
    bdm_cmd_t     cmd;
    bdm_alu_req_t req;

    assign cmd = bdm_cmd_t'(CMD_IN);
    assign req = '{op: bdm_op_t'(ALU_OP_IN), use_imm: ALU_IMM_IN, to_acc: ALU_TO_ACC_IN};

    // reset release through two flip-flops
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // resolve an address into {blocked, bank, effective address}
    function automatic logic [9:0] resolve(input bdm_state_t s, input logic [7:0] a);
        logic [7:0] eff;
        logic       bank;
        logic       blk;
        eff  = a;
        bank = 1'b0;
        blk  = 1'b0;
        if (a == BDM_ADDR_IND0) begin
            eff = s.ptr0;
        end else if (a == BDM_ADDR_IND1) begin
            eff  = s.ptr1;
            bank = s.bsel[0];
        end
        if ((a == BDM_ADDR_IND0 || a == BDM_ADDR_IND1) &&
            (eff == BDM_ADDR_IND0 || eff == BDM_ADDR_IND1)) begin
            blk = 1'b1;
        end
        return {blk, bank, eff};
    endfunction

    // data memory read, shared low registers first
    function automatic logic [7:0] mem_rd(input bdm_state_t s, input logic [7:0] a);
        logic [9:0] r;
        logic [7:0] idx;
        logic [7:0] d;
        r   = resolve(s, a);
        idx = r[7:0] - BDM_ADDR_GP_BASE;
        d   = BDM_BYTE_RST;
        if (r[9]) begin
            d = BDM_BYTE_RST;
        end else if (r[7:0] < BDM_ADDR_GP_BASE) begin
            case (r[7:0])
                BDM_ADDR_PTR0: d = s.ptr0;
                BDM_ADDR_PTR1: d = s.ptr1;
                BDM_ADDR_BSEL: d = s.bsel;
                BDM_ADDR_ACC:  d = s.acc;
                BDM_ADDR_STAT: d = s.stat;
                default:       d = BDM_BYTE_RST;
            endcase
        end else if (!r[8]) begin
            d = s.ram[idx];
        end
        return d;
    endfunction

    // data memory write; status keeps power-down and timeout
    function automatic bdm_state_t mem_wr(input bdm_state_t s, input logic [7:0] a, input logic [7:0] d);
        logic [9:0] r;
        logic [7:0] idx;
        bdm_state_t n;
        r   = resolve(s, a);
        idx = r[7:0] - BDM_ADDR_GP_BASE;
        n   = s;
        if (!r[9]) begin
            if (r[7:0] < BDM_ADDR_GP_BASE) begin
                case (r[7:0])
                    BDM_ADDR_PTR0: n.ptr0 = d;
                    BDM_ADDR_PTR1: n.ptr1 = d;
                    BDM_ADDR_BSEL: n.bsel = d;
                    BDM_ADDR_ACC:  n.acc  = d;
                    BDM_ADDR_STAT: n.stat = (s.stat & ~BDM_STAT_SW_MASK) | (d & BDM_STAT_SW_MASK);
                    default:       n.acc  = s.acc;
                endcase
            end else if (!r[8]) begin
                n.ram[idx] = d;
            end
        end
        return n;
    endfunction

    // operation, flags and watchdog events
    always_comb begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] bb;
        logic [7:0] res;
        logic [8:0] sum;
        logic [4:0] nib;
        logic [8:0] dadj;
        logic       cin;
        logic       wr_res;
        logic       fz;
        logic       fc;
        logic       fac;
        logic       fov;
        logic       sub;
        a      = q.acc;
        b      = req.use_imm ? WDATA_IN : mem_rd(q, ADDR_IN);
        bb     = 8'h00;
        res    = 8'h00;
        sum    = 9'h000;
        nib    = 5'h00;
        dadj   = 9'h000;
        cin    = 1'b0;
        wr_res = 1'b0;
        fz     = 1'b0;
        fc     = 1'b0;
        fac    = 1'b0;
        fov    = 1'b0;
        sub    = 1'b0;
        next_q      = q;
        next_q.skip = 1'b0;
        case (cmd)
            BDM_CMD_READ: begin
                next_q.rdata = mem_rd(q, ADDR_IN);
            end
            BDM_CMD_WRITE: begin
                next_q = mem_wr(q, ADDR_IN, WDATA_IN);
                next_q.skip = 1'b0;
            end
            BDM_CMD_ALU: begin
                wr_res = 1'b1;
                case (req.op)
                    BDM_OP_ADD, BDM_OP_ADC, BDM_OP_SUB, BDM_OP_SBC: begin
                        sub = (req.op == BDM_OP_SUB) || (req.op == BDM_OP_SBC);
                        bb  = sub ? ~b : b;
                        case (req.op)
                            BDM_OP_ADD: cin = 1'b0;
                            BDM_OP_SUB: cin = 1'b1;
                            default:    cin = q.stat[BDM_C_BIT];
                        endcase
                        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
                        nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
                        res = sum[7:0];
                        fc  = sum[8];
                        fac = nib[4];
                        fov = (a[7] == bb[7]) && (res[7] != a[7]);
                        fz  = (res == 8'h00);
                        next_q.stat[BDM_C_BIT]  = fc;
                        next_q.stat[BDM_AC_BIT] = fac;
                        next_q.stat[BDM_OV_BIT] = fov;
                        next_q.stat[BDM_Z_BIT]  = fz;
                    end
                    BDM_OP_DAA: begin
                        dadj = {1'b0, a};
                        if (a[3:0] > 4'h9 || q.stat[BDM_AC_BIT]) begin
                            dadj = dadj + 9'h006;
                        end
                        if (dadj[7:4] > 4'h9 || q.stat[BDM_C_BIT] || dadj[8]) begin
                            dadj = dadj + 9'h060;
                        end
                        res = dadj[7:0];
                        next_q.stat[BDM_C_BIT] = q.stat[BDM_C_BIT] | dadj[8];
                    end
                    BDM_OP_AND, BDM_OP_OR, BDM_OP_XOR, BDM_OP_CPL, BDM_OP_INC, BDM_OP_DEC: begin
                        case (req.op)
                            BDM_OP_AND: res = a & b;
                            BDM_OP_OR:  res = a | b;
                            BDM_OP_XOR: res = a ^ b;
                            BDM_OP_CPL: res = ~b;
                            BDM_OP_INC: res = b + 8'h01;
                            default:    res = b - 8'h01;
                        endcase
                        next_q.stat[BDM_Z_BIT] = (res == 8'h00);
                    end
                    BDM_OP_RL:  res = {b[6:0], b[7]};
                    BDM_OP_RR:  res = {b[0], b[7:1]};
                    BDM_OP_RLC: begin
                        res = {b[6:0], q.stat[BDM_C_BIT]};
                        next_q.stat[BDM_C_BIT] = b[7];
                    end
                    BDM_OP_RRC: begin
                        res = {q.stat[BDM_C_BIT], b[7:1]};
                        next_q.stat[BDM_C_BIT] = b[0];
                    end
                    BDM_OP_SZ, BDM_OP_SNZ: begin
                        wr_res      = 1'b0;
                        next_q.skip = (req.op == BDM_OP_SZ) ? (b == 8'h00) : (b != 8'h00);
                    end
                    BDM_OP_SIZ, BDM_OP_SDZ: begin
                        res         = (req.op == BDM_OP_SIZ) ? b + 8'h01 : b - 8'h01;
                        next_q.skip = (res == 8'h00);
                    end
                    default: wr_res = 1'b0;
                endcase
                if (wr_res) begin
                    if (req.to_acc) begin
                        next_q.acc = res;
                    end else begin
                        next_q = mem_wr(next_q, ADDR_IN, res);
                    end
                end
            end
            default: next_q.skip = 1'b0;
        endcase
        // power-down and timeout follow only their own events; a timeout wins over a clear
        if (WATCHDOG_CLEAR_INSTRUCTION_IN) begin
            next_q.stat[BDM_PDF_BIT] = 1'b0;
            next_q.stat[BDM_TO_BIT]  = 1'b0;
        end else if (HALT_IN) begin
            next_q.stat[BDM_PDF_BIT] = 1'b1;
            next_q.stat[BDM_TO_BIT]  = 1'b0;
        end else begin
            next_q.stat[BDM_PDF_BIT] = q.stat[BDM_PDF_BIT];
            next_q.stat[BDM_TO_BIT]  = q.stat[BDM_TO_BIT];
        end
        if (WDT_TIMEOUT_IN) begin
            next_q.stat[BDM_TO_BIT] = 1'b1;
        end
        next_q.stat[7:6] = 2'b00;
    end

    // state register; status lives only here, with no shadow copy kept for calls or interrupts
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{ram: '0, ptr0: BDM_BYTE_RST, ptr1: BDM_BYTE_RST, bsel: BDM_BYTE_RST,
                   acc: BDM_BYTE_RST, stat: BDM_STAT_RST, rdata: BDM_BYTE_RST, skip: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from the state flops
    assign RDATA_OUT  = q.rdata;
    assign SKIP_OUT   = q.skip;
    assign ACC_OUT    = q.acc;
    assign STATUS_OUT = q.stat;

    // checks
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!rst_n);

    AST_STAT_HIGH_ZERO: assert property (STATUS_OUT[7:6] == 2'b00)
        else $error("status bits 7:6 not zero");
    AST_SW_KEEPS_PDF_TO: assert property (
        cmd == BDM_CMD_WRITE && ADDR_IN == BDM_ADDR_STAT && !HALT_IN && !WATCHDOG_CLEAR_INSTRUCTION_IN && !WDT_TIMEOUT_IN
        |=> STATUS_OUT[5:4] == $past(STATUS_OUT[5:4]) && STATUS_OUT[3:0] == $past(WDATA_IN[3:0]))
        else $error("status write handled wrongly");
    AST_TO_CAUSE: assert property (
        $changed(STATUS_OUT[BDM_TO_BIT]) |-> $past(HALT_IN || WATCHDOG_CLEAR_INSTRUCTION_IN || WDT_TIMEOUT_IN))
        else $error("timeout flag changed without cause");
    AST_PDF_CAUSE: assert property (
        $changed(STATUS_OUT[BDM_PDF_BIT]) |-> $past(HALT_IN || WATCHDOG_CLEAR_INSTRUCTION_IN))
        else $error("power-down flag changed without cause");
    AST_HALT_SETS_PDF: assert property (
        HALT_IN && !WATCHDOG_CLEAR_INSTRUCTION_IN |=> STATUS_OUT[BDM_PDF_BIT] && !STATUS_OUT[BDM_TO_BIT] || $past(WDT_TIMEOUT_IN))
        else $error("halt did not set power-down");
    AST_TIMEOUT_SETS_TO: assert property (WDT_TIMEOUT_IN |=> STATUS_OUT[BDM_TO_BIT])
        else $error("watchdog timeout lost");
    AST_ACC_MAPPED: assert property (
        cmd == BDM_CMD_WRITE && ADDR_IN == BDM_ADDR_ACC ##1 cmd == BDM_CMD_NOP ##1
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_ACC
        |=> RDATA_OUT == $past(WDATA_IN, 3) && ACC_OUT == RDATA_OUT)
        else $error("accumulator not at 05h");
    AST_IND_BLOCKED: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND0 && (q.ptr0 == BDM_ADDR_IND0 || q.ptr0 == BDM_ADDR_IND1)
        |=> RDATA_OUT == 8'h00)
        else $error("indirect on indirect not zero");
    AST_RESERVED_ZERO: assert property (
        cmd == BDM_CMD_READ && ADDR_IN inside {[8'h06:8'h09], [8'h0b:8'h1f]} |=> RDATA_OUT == 8'h00)
        else $error("reserved location not zero");
    AST_SHARED_LOW: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND1 && q.bsel[0] && q.ptr1 == BDM_ADDR_ACC
        |=> RDATA_OUT == $past(ACC_OUT))
        else $error("bank 1 low register not shared");
    AST_PTR0_BANK0: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND0 && q.ptr0 >= BDM_ADDR_GP_BASE
        |=> RDATA_OUT == $past(q.ram[q.ptr0 - BDM_ADDR_GP_BASE]))
        else $error("pointer 0 left bank 0");
    AST_AND_ZERO: assert property (
        cmd == BDM_CMD_ALU && req.op == BDM_OP_AND && req.to_acc && req.use_imm
        |=> STATUS_OUT[BDM_Z_BIT] == (ACC_OUT == 8'h00))
        else $error("zero flag wrong after and");

    // steering of pointer 1 by the bank select, and status readback
    AST_BANK1_HIGH_ZERO: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND1 && q.bsel[0] && q.ptr1 >= BDM_ADDR_GP_BASE
        |=> RDATA_OUT == 8'h00)
        else $error("bank 1 general location not empty");
    AST_BANK1_WR_IGNORED: assert property (
        cmd == BDM_CMD_WRITE && ADDR_IN == BDM_ADDR_IND1 && q.bsel[0] && q.ptr1 >= BDM_ADDR_GP_BASE
        |=> q.ram == $past(q.ram))
        else $error("bank 1 write reached bank 0");
    AST_PTR1_BANK0: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND1 && !q.bsel[0] && q.ptr1 >= BDM_ADDR_GP_BASE
        |=> RDATA_OUT == $past(q.ram[q.ptr1 - BDM_ADDR_GP_BASE]))
        else $error("pointer 1 missed bank 0");
    AST_STAT_READBACK: assert property (
        cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_STAT |=> RDATA_OUT == $past(STATUS_OUT))
        else $error("status not readable at 0ah");

    // flags against the arithmetic they describe, then watchdog clear and skip pulse
    AST_ADD_CARRY: assert property (
        cmd == BDM_CMD_ALU && req.op == BDM_OP_ADD && req.use_imm && req.to_acc
        |=> STATUS_OUT[BDM_C_BIT] == ($past(ACC_OUT) > ~$past(WDATA_IN)) &&
            STATUS_OUT[BDM_AC_BIT] == ($past(ACC_OUT[3:0]) > ~$past(WDATA_IN[3:0])))
        else $error("carry flags wrong after add");
    AST_SUB_NO_BORROW: assert property (
        cmd == BDM_CMD_ALU && req.op == BDM_OP_SUB && req.use_imm && req.to_acc
        |=> STATUS_OUT[BDM_C_BIT] == ($past(ACC_OUT) >= $past(WDATA_IN)) &&
            STATUS_OUT[BDM_AC_BIT] == ($past(ACC_OUT[3:0]) >= $past(WDATA_IN[3:0])))
        else $error("borrow flags wrong after sub");
    AST_RRC_CARRY: assert property (
        cmd == BDM_CMD_ALU && req.op == BDM_OP_RRC && req.use_imm && req.to_acc
        |=> STATUS_OUT[BDM_C_BIT] == $past(WDATA_IN[0]))
        else $error("carry wrong after rotate right");
    AST_CLR_CLEARS: assert property (
        WATCHDOG_CLEAR_INSTRUCTION_IN && !WDT_TIMEOUT_IN |=> !STATUS_OUT[BDM_PDF_BIT] && !STATUS_OUT[BDM_TO_BIT])
        else $error("watchdog clear left a flag set");
    AST_SKIP_PULSE: assert property (SKIP_OUT && cmd != BDM_CMD_ALU |=> !SKIP_OUT)
        else $error("skip held beyond one cycle");

    COV_BANK1_ACCESS: cover property (cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND1 && q.bsel[0]);
    COV_ADD_CARRY:    cover property (cmd == BDM_CMD_ALU && req.op == BDM_OP_ADD ##1 STATUS_OUT[BDM_C_BIT]);
    COV_HALT:         cover property (HALT_IN ##1 STATUS_OUT[BDM_PDF_BIT]);
    COV_SKIP:         cover property (SKIP_OUT);
    COV_IND_BLOCKED:  cover property (cmd == BDM_CMD_READ && ADDR_IN == BDM_ADDR_IND0 && q.ptr0 == BDM_ADDR_IND1);

endmodule // bdm_top

// *** test/bdm_core_model.sv ***
// instruction unit model: issues one core command per issue call, three per mov, and idles between commands
// assumes the block takes a command at each rising edge of clk_in
`timescale 1ns/1ps
module bdm_core_model import bdm_pkg::*; (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic [7:0] acc_in,
    output logic [1:0]      cmd_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic [4:0]      op_out,
    output logic            imm_out,
    output logic            to_acc_out,
    output logic [2:0]      evt_out
);
    // idle from time zero
    initial begin
        {cmd_out, addr_out, wdata_out, op_out, imm_out, to_acc_out, evt_out} = '0;
    end

    // hold one command across one taking edge; released cmd and evt drop to zero, the other fields show the inverse, not stale values
    task automatic issue(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d,
                         input logic [4:0] o, input logic i, input logic t, input logic [2:0] e);
        @(posedge clk_in);
        {cmd_out, addr_out, wdata_out, op_out, imm_out, to_acc_out, evt_out} <= {c, a, d, o, i, t, e};
        @(posedge clk_in);
        {cmd_out, evt_out} <= '0;
        {addr_out, wdata_out, op_out, imm_out, to_acc_out} <= ~{a, d, o, i, t};
        #1;
    endtask

    // read one location, data sampled 1 ns after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        issue(BDM_CMD_READ, a, 8'h00, 5'h00, 1'b0, 1'b0, 3'b000);
        v = rdata_in;
    endtask

    // memory to memory copy passes through the accumulator
    task automatic mov(input logic [7:0] src, input logic [7:0] dst);
        logic [7:0] v;
        rd(src, v);
        issue(BDM_CMD_WRITE, BDM_ADDR_ACC, v, 5'h00, 1'b0, 1'b0, 3'b000);
        issue(BDM_CMD_WRITE, dst, acc_in, 5'h00, 1'b0, 1'b0, 3'b000);
    endtask
endmodule // bdm_core_model

// *** test/bdm_top_tb_top.sv ***
// self-checking bench for the banked data memory and status block
// assumes one 20 MHz core clock and the instruction unit model beside the block
`timescale 1ns/1ps
module bdm_top_tb_top import bdm_pkg::*;;
    localparam int LIMIT = 2000;
    logic       clk;
    logic       rst_n;
    logic [1:0] cmd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [4:0] op;
    logic       imm;
    logic       to_acc;
    logic [2:0] evt;
    logic [7:0] rdata;
    logic       skip;
    logic [7:0] acc;
    logic [7:0] stat;
    int         fail_count;
    int         checked;
    int         cyc;

    bdm_top bdm_top_inst (.CORE_CLK_IN(clk), .RSTN_IN(rst_n), .CMD_IN(cmd), .ADDR_IN(addr),
        .WDATA_IN(wdata), .ALU_OP_IN(op), .ALU_IMM_IN(imm), .ALU_TO_ACC_IN(to_acc), .HALT_IN(evt[0]),
        .WATCHDOG_CLEAR_INSTRUCTION_IN(evt[1]), .WDT_TIMEOUT_IN(evt[2]), .RDATA_OUT(rdata), .SKIP_OUT(skip),
        .ACC_OUT(acc), .STATUS_OUT(stat));
    bdm_core_model bdm_core_model_inst (.clk_in(clk), .rdata_in(rdata), .acc_in(acc), .cmd_out(cmd),
        .addr_out(addr), .wdata_out(wdata), .op_out(op), .imm_out(imm), .to_acc_out(to_acc),
        .evt_out(evt));

    // clock, and a ceiling on run length
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            finish_test();
        end
    end

    // counts, verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // byte comparison
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bus helpers over the instruction unit model
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bdm_core_model_inst.issue(BDM_CMD_WRITE, a, d, 5'h00, 1'b0, 1'b0, 3'b000);
    endtask
    task automatic alu(input bdm_op_t o, input logic i, input logic t, input logic [7:0] a,
                       input logic [7:0] d);
        bdm_core_model_inst.issue(BDM_CMD_ALU, a, d, o, i, t, 3'b000);
    endtask
    task automatic pulse(input logic [2:0] e);
        bdm_core_model_inst.issue(BDM_CMD_NOP, 8'h00, 8'h00, 5'h00, 1'b0, 1'b0, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] v;
        bdm_core_model_inst.rd(a, v);
        chk(name, exp, v);
    endtask

    // reset contents of the mapped registers other than the accumulator
    task automatic t_reset();
        chk("status port", 8'h00, stat);
        rchk(BDM_ADDR_PTR0, 8'h00, "ptr0");
        rchk(BDM_ADDR_PTR1, 8'h00, "ptr1");
        rchk(BDM_ADDR_BSEL, 8'h00, "bank select");
        $display("done reset values");
    endtask

    // accumulator mapping, immediate operand and copy through it
    task automatic t_acc();
        wr(BDM_ADDR_ACC, 8'h3c);
        chk("acc port", 8'h3c, acc);
        rchk(BDM_ADDR_ACC, 8'h3c, "acc read");
        alu(BDM_OP_ADD, 1'b1, 1'b1, 8'h00, 8'h01);
        chk("acc immediate", 8'h3d, acc);
        wr(8'h40, 8'h5a);
        bdm_core_model_inst.mov(8'h40, 8'h22);
        rchk(8'h22, 8'h5a, "moved byte");
        $display("done accumulator");
    endtask

    // pointers, bank steering, pointer aimed at an indirect slot, reserved slot
    task automatic t_ind();
        wr(BDM_ADDR_PTR0, 8'h40);
        rchk(BDM_ADDR_IND0, 8'h5a, "ind0");
        wr(BDM_ADDR_BSEL, 8'h01);
        rchk(BDM_ADDR_IND0, 8'h5a, "ind0 with bank 1");
        wr(BDM_ADDR_PTR1, 8'h40);
        rchk(BDM_ADDR_IND1, 8'h00, "ind1 bank 1 high");
        wr(BDM_ADDR_IND1, 8'h99);
        wr(BDM_ADDR_PTR1, BDM_ADDR_ACC);
        rchk(BDM_ADDR_IND1, 8'h5a, "ind1 bank 1 shared");
        wr(BDM_ADDR_BSEL, 8'h00);
        rchk(8'h40, 8'h5a, "bank 0 untouched");
        wr(BDM_ADDR_PTR1, 8'hff);
        wr(BDM_ADDR_IND1, 8'hc3);
        rchk(BDM_ADDR_IND1, 8'hc3, "ind1 bank 0");
        rchk(8'hff, 8'hc3, "ind1 top address");
        wr(BDM_ADDR_PTR0, BDM_ADDR_IND1);
        rchk(BDM_ADDR_IND0, 8'h00, "pointer on indirect");
        wr(BDM_ADDR_IND0, 8'h77);
        rchk(8'hff, 8'hc3, "write ignored");
        wr(8'h0c, 8'hff);
        rchk(8'h0c, 8'h00, "reserved slot");
        $display("done indirect");
    endtask

    // protected flags against software writes and the watchdog and halt events
    task automatic t_stat();
        pulse(3'b001);
        chk("halt", 8'h10, stat);
        pulse(3'b100);
        chk("timeout", 8'h30, stat);
        wr(BDM_ADDR_STAT, 8'hff);
        chk("write ones", 8'h3f, stat);
        rchk(BDM_ADDR_STAT, 8'h3f, "status read");
        wr(BDM_ADDR_STAT, 8'h00);
        chk("write zeros", 8'h30, stat);
        pulse(3'b001);
        chk("halt clears timeout", 8'h10, stat);
        pulse(3'b010);
        chk("watchdog clear", 8'h00, stat);
        $display("done status");
    endtask

    // one alu op into the accumulator, result and low flags judged
    task automatic arow(input bdm_op_t o, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] r, input logic [3:0] f);
        wr(BDM_ADDR_ACC, a);
        alu(o, 1'b1, 1'b1, 8'h00, b);
        chk("alu result", r, acc);
        chk("alu flags", {4'h0, f}, stat);
    endtask

    // every operation except the four skips, flags carried from row to row
    task automatic t_alu();
        arow(BDM_OP_ADD, 8'hff, 8'h01, 8'h00, 4'h7);
        arow(BDM_OP_ADC, 8'h00, 8'h00, 8'h01, 4'h0);
        arow(BDM_OP_ADD, 8'h7f, 8'h01, 8'h80, 4'ha);
        arow(BDM_OP_SUB, 8'h05, 8'h05, 8'h00, 4'h7);
        arow(BDM_OP_SUB, 8'h00, 8'h01, 8'hff, 4'h0);
        arow(BDM_OP_INC, 8'h00, 8'hff, 8'h00, 4'h4);
        arow(BDM_OP_DEC, 8'h00, 8'h01, 8'h00, 4'h4);
        arow(BDM_OP_CPL, 8'h00, 8'h0f, 8'hf0, 4'h0);
        arow(BDM_OP_AND, 8'hf0, 8'h0f, 8'h00, 4'h4);
        arow(BDM_OP_OR, 8'h12, 8'h01, 8'h13, 4'h0);
        arow(BDM_OP_XOR, 8'h55, 8'h55, 8'h00, 4'h4);
        arow(BDM_OP_SBC, 8'h05, 8'h04, 8'h00, 4'h7);
        arow(BDM_OP_RLC, 8'h00, 8'h80, 8'h01, 4'h7);
        arow(BDM_OP_RRC, 8'h00, 8'h00, 8'h80, 4'h6);
        arow(BDM_OP_RL, 8'h00, 8'h81, 8'h03, 4'h6);
        arow(BDM_OP_RR, 8'h00, 8'h81, 8'hc0, 4'h6);
        arow(BDM_OP_DAA, 8'h0a, 8'h00, 8'h10, 4'h6);
        wr(8'h21, 8'h41);
        alu(BDM_OP_INC, 1'b0, 1'b0, 8'h21, 8'h00);
        rchk(8'h21, 8'h42, "alu to memory");
        $display("done alu");
    endtask

    // skip tests: pulse and written value
    task automatic srow(input bdm_op_t o, input logic [7:0] b, input logic s, input logic [7:0] r);
        wr(BDM_ADDR_ACC, 8'h99);
        alu(o, 1'b1, 1'b1, 8'h00, b);
        chk("skip pulse", {7'h00, s}, {7'h00, skip});
        chk("skip result", r, acc);
    endtask
    task automatic t_skip();
        srow(BDM_OP_SZ, 8'h00, 1'b1, 8'h99);
        srow(BDM_OP_SNZ, 8'h00, 1'b0, 8'h99);
        srow(BDM_OP_SIZ, 8'hff, 1'b1, 8'h00);
        srow(BDM_OP_SDZ, 8'h05, 1'b0, 8'h04);
        $display("done skip");
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset();
        t_acc();
        t_ind();
        t_stat();
        t_alu();
        t_skip();
        finish_test();
    end
endmodule // bdm_top_tb_top
